// [core/boag_addr_gen.sv]
// branch target and operand address generation for the 8-bit core
// ------------------------------------------------------------
// What this block does
// - absolute call or jump loads the 16-bit immediate target into the program counter.
// - a table call uses opcode bits 1..5 to pick an entry in 40H..7FH and loads it.
// - the register jump copies the accumulator pair into the program counter.
// - direct operands use the full 16-bit immediate address.
// - short direct reaches the 256-byte window FE20H..FF1FH from an 8-bit field.
// - short direct bit 8 is 0 for fields 20H..FFH and 1 for fields 00H..1FH.
// - special register addressing maps an 8-bit field onto FF00H..FFFFH.
// - a 3-bit field picks one of eight byte registers, a 2-bit field one of four pairs.
// - register indirect uses the second pointer pair or base pointer pair as address.
// - based addressing adds the zero-extended byte to the base pair, dropping carry.
// - push, pop and call address the stack via the stack pointer; return takes its target from the immediate field.
// - relative branches add a signed byte to the next instruction address.
// - without a branch the program counter advances by the bytes fetched.
// ------------------------------------------------------------
`timescale 1ns/100ps
module boag_addr_gen (
  clock,
  reset_n,
  instr_valid,
  instr_ready,
  instr_len,
  branch_kind,
  is_call,
  opcode,
  absolute_target_field,
  relative_displacement,
  operand_byte,
  op_mode,
  pair_select,
  reg_select,
  stack_op,
  stack_load,
  stack_load_value,
  accumulator_pair,
  second_pointer_pair,
  base_pointer_pair,
  mem_rdata,
  mem_req,
  mem_we,
  mem_addr,
  mem_wdata,
  operand_addr,
  byte_reg_index,
  pair_reg_index,
  program_counter,
  stack_pointer_reg
);
  input  wire logic                  clock;
  input  wire logic                  reset_n;
  input  wire logic                  instr_valid;
  output      logic                  instr_ready;
  input  wire logic [1:0]            instr_len;
  input  wire boag_pkg::boag_branch_t branch_kind;
  input  wire logic                  is_call;
  input  wire logic [7:0]            opcode;
  input  wire logic [15:0]           absolute_target_field;
  input  wire logic [7:0]            relative_displacement;
  input  wire logic [7:0]            operand_byte;
  input  wire boag_pkg::boag_opmode_t op_mode;
  input  wire logic                  pair_select;
  input  wire logic [2:0]            reg_select;
  input  wire boag_pkg::boag_stack_t stack_op;
  input  wire logic                  stack_load;
  input  wire logic [15:0]           stack_load_value;
  input  wire logic [15:0]           accumulator_pair;
  input  wire logic [15:0]           second_pointer_pair;
  input  wire logic [15:0]           base_pointer_pair;
  input  wire logic [7:0]            mem_rdata;
  output      logic                  mem_req;
  output      logic                  mem_we;
  output      logic [15:0]           mem_addr;
  output      logic [7:0]            mem_wdata;
  output      logic [15:0]           operand_addr;
  output      logic [7:0]            byte_reg_index;
  output      logic [1:0]            pair_reg_index;
  output      logic [15:0]           program_counter;
  output      logic [15:0]           stack_pointer_reg;

  import boag_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  boag_state_t state_reg;
  boag_state_t state_next;
  logic [15:0] pc_reg;
  logic [15:0] pc_next;
  logic [15:0] sptr_reg;
  logic [15:0] sptr_next;
  logic [15:0] ret_reg;
  logic [15:0] ret_next;
  logic [15:0] tgt_reg;
  logic [15:0] tgt_next;
  logic        tbl_reg;
  logic        tbl_next;
  logic [7:0]  lo_reg;
  logic [7:0]  lo_next;
  logic [15:0] opaddr_reg;
  logic [15:0] opaddr_next;
  logic [7:0]  breg_reg;
  logic [1:0]  preg_reg;
  logic [15:0] tbl_base_reg;

  // ------------------------------------------------------------
  // address arithmetic
  // ------------------------------------------------------------
  wire logic [15:0] seq_pc;
  wire logic [15:0] rel_pc;
  wire logic [15:0] based_addr;
  wire logic [15:0] short_addr;
  wire logic [15:0] special_addr;
  wire logic [15:0] table_addr;
  wire logic [15:0] table_addr_hi;
  wire logic [15:0] sptr_dec;
  wire logic [15:0] sptr_inc;
  wire logic [15:0] indir_addr;
  wire logic        idle;
  wire logic        take;
  wire logic        is_push_call;

  assign seq_pc       = pc_reg + {14'h0000, instr_len};
  assign table_addr   = TABLE_BASE + {10'h000, opcode[TBL_MSB:TBL_LSB], 1'b0};
  assign table_addr_hi = table_addr + 16'h0001;
  assign sptr_dec     = sptr_reg - 16'h0001;
  assign sptr_inc     = sptr_reg + 16'h0001;
  assign indir_addr   = pair_select ? base_pointer_pair : second_pointer_pair;
  assign idle         = (state_reg == ST_IDLE);
  assign take         = idle & instr_valid;
  assign is_push_call = is_call & ((branch_kind == TGT_ABS) | (branch_kind == TGT_TABLE));
  assign instr_ready  = idle;

  boag_adder16 u_rel_add (
    .base     (seq_pc),
    .offset   (relative_displacement),
    .sign_ext (1'b1),
    .sum      (rel_pc)
  );
  boag_adder16 u_based_add (
    .base     (base_pointer_pair),
    .offset   (operand_byte),
    .sign_ext (1'b0),
    .sum      (based_addr)
  );
  boag_short_map u_short (
    .field   (operand_byte),
    .special (1'b0),
    .addr    (short_addr)
  );
  boag_short_map u_special (
    .field   (operand_byte),
    .special (1'b1),
    .addr    (special_addr)
  );

  // ------------------------------------------------------------
  // operand effective address
  // ------------------------------------------------------------
  always_comb begin
    case (op_mode)
      OP_DIRECT:  opaddr_next = absolute_target_field;
      OP_SHORT:   opaddr_next = short_addr;
      OP_SPECIAL: opaddr_next = special_addr;
      OP_INDIR:   opaddr_next = indir_addr;
      OP_BASED:   opaddr_next = based_addr;
      OP_STACK:   opaddr_next = (stack_op == STK_POP) ? sptr_reg : sptr_dec;
      default:    opaddr_next = absolute_target_field;
    endcase
  end

  // ------------------------------------------------------------
  // sequencer: pushes return address, fetches table entries
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    pc_next    = pc_reg;
    sptr_next  = sptr_reg;
    ret_next   = ret_reg;
    tgt_next   = tgt_reg;
    tbl_next   = tbl_reg;
    lo_next    = lo_reg;
    case (state_reg)
      ST_IDLE: begin
        if (stack_load) begin
          sptr_next = stack_load_value;
        end
        if (take) begin
          ret_next = seq_pc;
          tgt_next = absolute_target_field;
          tbl_next = (branch_kind == TGT_TABLE);
          case (branch_kind)
            TGT_SEQ:   pc_next = seq_pc;
            TGT_ABS:   pc_next = is_call ? pc_reg : absolute_target_field;
            TGT_REG:   pc_next = accumulator_pair;
            TGT_REL:   pc_next = rel_pc;
            TGT_RET:   pc_next = absolute_target_field;
            TGT_TABLE: pc_next = pc_reg;
            default:   pc_next = seq_pc;
          endcase
          if (is_push_call) begin
            state_next = ST_PUSH_H;
          end else if (branch_kind == TGT_TABLE) begin
            state_next = ST_TBL_L;
          end
          if (!stack_load && (op_mode == OP_STACK)) begin
            if (stack_op == STK_PUSH) begin
              sptr_next = sptr_dec;
            end else if (stack_op == STK_POP) begin
              sptr_next = sptr_inc;
            end
          end
        end
      end
      ST_PUSH_H: begin
        sptr_next  = sptr_dec;
        state_next = ST_PUSH_L;
      end
      ST_PUSH_L: begin
        sptr_next = sptr_dec;
        if (tbl_reg) begin
          state_next = ST_TBL_L;
        end else begin
          pc_next    = tgt_reg;
          state_next = ST_IDLE;
        end
      end
      ST_TBL_L: begin
        lo_next    = mem_rdata;
        state_next = ST_TBL_H;
      end
      ST_TBL_H: begin
        pc_next    = {mem_rdata, lo_reg};
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // table lookups read memory combinationally: data arrives the same cycle
  assign mem_req   = ~idle;
  assign mem_we    = (state_reg == ST_PUSH_H) | (state_reg == ST_PUSH_L);
  assign mem_addr  = (state_reg == ST_TBL_L) ? tbl_base_reg :
                     (state_reg == ST_TBL_H) ? tbl_base_reg + 16'h0001 :
                     sptr_dec;
  assign mem_wdata = (state_reg == ST_PUSH_H) ? ret_reg[15:8] : ret_reg[7:0];

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      pc_reg    <= PC_RESET;
      sptr_reg  <= STKPTR_RESET;
      ret_reg   <= 16'h0000;
      tgt_reg   <= 16'h0000;
      tbl_reg   <= 1'b0;
      lo_reg    <= 8'h00;
    end else begin
      state_reg <= state_next;
      pc_reg    <= pc_next;
      sptr_reg  <= sptr_next;
      ret_reg   <= ret_next;
      tgt_reg   <= tgt_next;
      tbl_reg   <= tbl_next;
      lo_reg    <= lo_next;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      opaddr_reg   <= 16'h0000;
      breg_reg     <= 8'h00;
      preg_reg     <= 2'h0;
      tbl_base_reg <= TABLE_BASE;
    end else if (take) begin
      opaddr_reg   <= opaddr_next;
      breg_reg     <= 8'h01 << reg_select;
      preg_reg     <= reg_select[2:1];
      tbl_base_reg <= table_addr;
    end
  end

  assign operand_addr      = opaddr_reg;
  assign byte_reg_index    = breg_reg;
  assign pair_reg_index    = preg_reg;
  assign program_counter   = pc_reg;
  assign stack_pointer_reg = sptr_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_ABS_JUMP: assert property (@(posedge clock) disable iff (!reset_n)
    take && branch_kind == TGT_ABS && !is_call |=> pc_reg == $past(absolute_target_field))
    else $error("absolute jump target not loaded");
  AST_TABLE_FETCH: assert property (@(posedge clock) disable iff (!reset_n)
    idle && instr_valid && branch_kind == TGT_TABLE && !is_call
    |=> state_reg == ST_TBL_L ##1 state_reg == ST_TBL_H ##1 idle)
    else $error("table call sequence wrong");
  AST_TABLE_ADDR: assert property (@(posedge clock) disable iff (!reset_n)
    state_reg == ST_TBL_L |-> mem_addr >= 16'h0040 && mem_addr <= 16'h007E && !mem_addr[0])
    else $error("table entry address out of range");
  AST_REG_JUMP: assert property (@(posedge clock) disable iff (!reset_n)
    take && branch_kind == TGT_REG |=> pc_reg == $past(accumulator_pair))
    else $error("register jump target wrong");
  AST_SHORT_BIT8: assert property (@(posedge clock) disable iff (!reset_n)
    take && op_mode == OP_SHORT
    |=> operand_addr[SHORT_BIT8] == ($past(operand_byte) < 8'h20)
        && operand_addr[15:9] == 7'h7F)
    else $error("short direct bit 8 wrong");
  AST_BASED: assert property (@(posedge clock) disable iff (!reset_n)
    take && op_mode == OP_BASED
    |=> operand_addr == 16'($past(base_pointer_pair) + {8'h00, $past(operand_byte)}))
    else $error("based address wrong");
  AST_SEQ_PC: assert property (@(posedge clock) disable iff (!reset_n)
    take && branch_kind == TGT_SEQ |=> pc_reg == 16'($past(pc_reg) + $past(instr_len)))
    else $error("sequential pc advance wrong");
  AST_CALL_PUSH: assert property (@(posedge clock) disable iff (!reset_n)
    take && branch_kind == TGT_ABS && is_call
    |=> mem_we && mem_wdata == $past(seq_pc[15:8]) ##1 mem_we ##1
        pc_reg == $past(tgt_reg, 2))
    else $error("call push sequence wrong");
  AST_REL: assert property (@(posedge clock) disable iff (!reset_n)
    take && branch_kind == TGT_REL
    |=> pc_reg == 16'($past(seq_pc) + {{8{$past(relative_displacement[7])}},
                                     $past(relative_displacement)}))
    else $error("relative branch target wrong");

endmodule : boag_addr_gen

// [common/boag_pkg.sv]
// constants and types for the branch and operand address generator
package boag_pkg;

  // ------------------------------------------------------------
  // branch target kinds
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    TGT_SEQ   = 3'h0,
    TGT_ABS   = 3'h1,
    TGT_TABLE = 3'h2,
    TGT_REG   = 3'h3,
    TGT_REL   = 3'h4,
    TGT_RET   = 3'h5
  } boag_branch_t;

  // ------------------------------------------------------------
  // operand address modes
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_DIRECT  = 3'h0,
    OP_SHORT   = 3'h1,
    OP_SPECIAL = 3'h2,
    OP_INDIR   = 3'h3,
    OP_BASED   = 3'h4,
    OP_STACK   = 3'h5
  } boag_opmode_t;

  // ------------------------------------------------------------
  // stack operation kinds
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    STK_NONE = 2'h0,
    STK_PUSH = 2'h1,
    STK_POP  = 2'h2
  } boag_stack_t;

  // ------------------------------------------------------------
  // sequencer states, one-hot
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_PUSH_H = 5'h02,
    ST_PUSH_L = 5'h04,
    ST_TBL_L  = 5'h08,
    ST_TBL_H  = 5'h10
  } boag_state_t;

  // ------------------------------------------------------------
  // address map constants
  // ------------------------------------------------------------
  localparam logic [15:0] PC_RESET      = 16'h0000;
  localparam logic [15:0] STKPTR_RESET  = 16'hFF00;
  localparam logic [15:0] TABLE_BASE    = 16'h0040;
  localparam logic [15:0] SHORT_BASE_LO = 16'hFE00;
  localparam logic [7:0]  SHORT_SPLIT   = 8'h20;
  localparam logic [7:0]  SPECIAL_HIGH  = 8'hFF;
  localparam logic [7:0]  SHORT_HIGH_LO = 8'hFE;
  localparam logic [7:0]  SHORT_HIGH_HI = 8'hFF;
  localparam int          SHORT_BIT8    = 8;
  localparam int          REL_SIGN_BIT  = 7;
  localparam int          TBL_LSB       = 1;
  localparam int          TBL_MSB       = 5;

endpackage : boag_pkg

// [core/boag_adder16.sv]
// 16-bit wrapping adder with zero or sign extended byte operand
`timescale 1ns/100ps
module boag_adder16 (
  base,
  offset,
  sign_ext,
  sum
);
  input  wire logic [15:0] base;
  input  wire logic [7:0]  offset;
  input  wire logic        sign_ext;
  output      logic [15:0] sum;

  import boag_pkg::*;

  wire logic        fill_bit;
  wire logic [15:0] ext_offset;
  wire logic [16:0] full_sum;

  assign fill_bit   = sign_ext & offset[REL_SIGN_BIT];
  assign ext_offset = {{8{fill_bit}}, offset};
  assign full_sum   = {1'b0, base} + {1'b0, ext_offset};
  // carry out of bit 15 is dropped
  assign sum        = full_sum[15:0];

endmodule : boag_adder16

// [core/boag_short_map.sv]
// maps a one-byte operand field onto the short or special window
`timescale 1ns/100ps
module boag_short_map (
  field,
  special,
  addr
);
  input  wire logic [7:0]  field;
  input  wire logic        special;
  output      logic [15:0] addr;

  import boag_pkg::*;

  wire logic       low_field;
  wire logic [7:0] high_byte;

  assign low_field = (field < SHORT_SPLIT);
  // in the short window bit 8 is one only for fields below the split
  assign high_byte = special   ? SPECIAL_HIGH  :
                     low_field ? SHORT_HIGH_HI : SHORT_HIGH_LO;
  assign addr      = {high_byte, field};

endmodule : boag_short_map

// [dv/boag_mem_model.sv]
// behavioural memory standing behind the address generator's bus
`timescale 1ns/100ps
module boag_mem_model (
  clock,
  mem_req,
  mem_we,
  mem_addr,
  mem_wdata,
  mem_rdata
);
  input  wire logic        clock;
  input  wire logic        mem_req;
  input  wire logic        mem_we;
  input  wire logic [15:0] mem_addr;
  input  wire logic [7:0]  mem_wdata;
  output      logic [7:0]  mem_rdata;

  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[7:0] ^ 8'h5A;
    end
  end

  // idle bus shows the inverse of the last byte, never a stale match
  assign mem_rdata = mem_req ? mem[mem_addr] : ~last_q;

  always @(posedge clock) begin
    if (mem_req) begin
      last_q <= mem[mem_addr];
    end
    if (mem_req && mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule : boag_mem_model

// [dv/boag_addr_gen_test.sv]
// self-checking bench for the branch and operand address generator
`timescale 1ns/100ps
module boag_addr_gen_test;
  import boag_pkg::*;

  logic         clock;
  logic         reset_n;
  logic         instr_valid;
  logic         instr_ready;
  logic [1:0]   instr_len;
  boag_branch_t branch_kind;
  logic         is_call;
  logic [7:0]   opcode;
  logic [15:0]  absolute_target_field;
  logic [7:0]   relative_displacement;
  logic [7:0]   operand_byte;
  boag_opmode_t op_mode;
  logic         pair_select;
  logic [2:0]   reg_select;
  boag_stack_t  stack_op;
  logic         stack_load;
  logic [15:0]  stack_load_value;
  logic [15:0]  accumulator_pair;
  logic [15:0]  second_pointer_pair;
  logic [15:0]  base_pointer_pair;
  logic [7:0]   mem_rdata;
  logic         mem_req;
  logic         mem_we;
  logic [15:0]  mem_addr;
  logic [7:0]   mem_wdata;
  logic [15:0]  operand_addr;
  logic [7:0]   byte_reg_index;
  logic [1:0]   pair_reg_index;
  logic [15:0]  program_counter;
  logic [15:0]  stack_pointer_reg;
  logic [15:0]  epc;
  logic [15:0]  esp;
  int           n_mismatch;
  int           num_checks;

  boag_addr_gen DUT (.clock(clock), .reset_n(reset_n), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .instr_len(instr_len), .branch_kind(branch_kind),
    .is_call(is_call), .opcode(opcode), .absolute_target_field(absolute_target_field),
    .relative_displacement(relative_displacement), .operand_byte(operand_byte),
    .op_mode(op_mode), .pair_select(pair_select), .reg_select(reg_select),
    .stack_op(stack_op), .stack_load(stack_load), .stack_load_value(stack_load_value),
    .accumulator_pair(accumulator_pair), .second_pointer_pair(second_pointer_pair),
    .base_pointer_pair(base_pointer_pair), .mem_rdata(mem_rdata), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .operand_addr(operand_addr), .byte_reg_index(byte_reg_index),
    .pair_reg_index(pair_reg_index), .program_counter(program_counter),
    .stack_pointer_reg(stack_pointer_reg));

  boag_mem_model mem_model (.clock(clock), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic report_and_stop;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] a, input logic [15:0] e);
    num_checks++;
    if (a !== e) begin
      n_mismatch++;
      $display("mismatch %0t got %h expected %h", $time, a, e);
    end
  endtask : chk

  // one idle cycle after each take keeps valid from being set twice in one step
  task automatic go(input boag_branch_t bk, input boag_opmode_t m);
    branch_kind = bk;
    op_mode = m;
    instr_valid = 1'b1;
    @(posedge clock);
    #1;
    instr_valid = 1'b0;
    for (int i = 0; i < 8 && instr_ready !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    chk({15'h0000, instr_ready}, 16'h0001);
    @(posedge clock);
    #1;
  endtask : go

  task automatic op(input boag_opmode_t m, input logic [7:0] b, input logic [15:0] e);
    operand_byte = b;
    instr_len = 2'h2;
    go(TGT_SEQ, m);
    epc = epc + 16'h0002;
    chk(operand_addr, e);
    chk(program_counter, epc);
  endtask : op

  task automatic chk_push(input logic [15:0] ret);
    chk(stack_pointer_reg, esp - 16'h0002);
    chk({8'h00, mem_model.mem[esp - 16'h0001]}, {8'h00, ret[15:8]});
    chk({8'h00, mem_model.mem[esp - 16'h0002]}, {8'h00, ret[7:0]});
    esp = esp - 16'h0002;
  endtask : chk_push

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_branches;
    instr_len = 2'h3;
    absolute_target_field = 16'hFE00;
    go(TGT_SEQ, OP_DIRECT);
    epc = epc + 16'h0003;
    chk(program_counter, epc);
    chk(operand_addr, 16'hFE00);
    absolute_target_field = 16'h8000;
    go(TGT_ABS, OP_DIRECT);
    chk(program_counter, 16'h8000);
    accumulator_pair = 16'h4321;
    go(TGT_REG, OP_DIRECT);
    chk(program_counter, 16'h4321);
    instr_len = 2'h2;
    relative_displacement = 8'h80;
    go(TGT_REL, OP_DIRECT);
    epc = 16'h4321 + 16'h0002 - 16'h0080;
    chk(program_counter, epc);
    relative_displacement = 8'h7F;
    go(TGT_REL, OP_DIRECT);
    epc = epc + 16'h0002 + 16'h007F;
    chk(program_counter, epc);
  endtask : t_branches

  task automatic t_calls;
    mem_model.mem[16'h007E] = 8'h34;
    mem_model.mem[16'h007F] = 8'h12;
    mem_model.mem[16'h0040] = 8'hCD;
    mem_model.mem[16'h0041] = 8'hAB;
    opcode = 8'h3E;
    go(TGT_TABLE, OP_DIRECT);
    chk(program_counter, 16'h1234);
    // bit 0 set: only bits 5..1 may select the entry
    opcode = 8'h01;
    is_call = 1'b1;
    instr_len = 2'h1;
    go(TGT_TABLE, OP_DIRECT);
    chk(program_counter, 16'hABCD);
    chk_push(16'h1235);
    instr_len = 2'h3;
    absolute_target_field = 16'h2000;
    go(TGT_ABS, OP_DIRECT);
    chk(program_counter, 16'h2000);
    chk_push(16'hABD0);
    is_call = 1'b0;
    // return target is handed back from the stack by the fetch side
    absolute_target_field = {mem_model.mem[esp + 16'h0001], mem_model.mem[esp]};
    go(TGT_RET, OP_DIRECT);
    chk(program_counter, 16'hABD0);
    epc = 16'hABD0;
  endtask : t_calls

  task automatic t_operands;
    op(OP_SHORT, 8'h20, 16'hFE20);
    op(OP_SHORT, 8'h1F, 16'hFF1F);
    op(OP_SHORT, 8'hFF, 16'hFEFF);
    op(OP_SHORT, 8'h00, 16'hFF00);
    op(OP_SPECIAL, 8'h20, 16'hFF20);
    op(OP_SPECIAL, 8'hFF, 16'hFFFF);
    second_pointer_pair = 16'h1357;
    base_pointer_pair = 16'hFFF0;
    pair_select = 1'b0;
    op(OP_INDIR, 8'h00, 16'h1357);
    pair_select = 1'b1;
    op(OP_INDIR, 8'h00, 16'hFFF0);
    op(OP_BASED, 8'hF0, 16'h00E0);
    op(OP_BASED, 8'h0F, 16'hFFFF);
    stack_op = STK_PUSH;
    op(OP_STACK, 8'h00, esp - 16'h0001);
    esp = esp - 16'h0001;
    chk(stack_pointer_reg, esp);
    stack_op = STK_POP;
    op(OP_STACK, 8'h00, esp);
    esp = esp + 16'h0001;
    chk(stack_pointer_reg, esp);
    stack_op = STK_NONE;
  endtask : t_operands

  task automatic t_registers;
    for (int r = 0; r < 8; r++) begin
      reg_select = r[2:0];
      op(OP_DIRECT, 8'h00, absolute_target_field);
      chk({8'h00, byte_reg_index}, {8'h00, 8'h01 << r});
      chk({14'h0000, pair_reg_index}, {14'h0000, reg_select[2:1]});
    end
  endtask : t_registers

  // ------------------------------------------------------------
  // clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    #20000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    n_mismatch = 0;
    num_checks = 0;
    reset_n = 1'b0;
    instr_valid = 1'b0;
    instr_len = 2'h1;
    branch_kind = TGT_SEQ;
    is_call = 1'b0;
    opcode = 8'h00;
    absolute_target_field = 16'h0000;
    relative_displacement = 8'h00;
    operand_byte = 8'h00;
    op_mode = OP_DIRECT;
    pair_select = 1'b0;
    reg_select = 3'h0;
    stack_op = STK_NONE;
    stack_load = 1'b0;
    stack_load_value = 16'h0000;
    accumulator_pair = 16'h0000;
    second_pointer_pair = 16'h0000;
    base_pointer_pair = 16'h0000;
    repeat (2) @(posedge clock);
    #1;
    reset_n = 1'b1;
    chk(program_counter, PC_RESET);
    chk(stack_pointer_reg, STKPTR_RESET);
    chk({15'h0000, mem_req}, 16'h0000);
    epc = PC_RESET;
    // stack kept inside high-speed RAM
    stack_load_value = 16'hFE80;
    stack_load = 1'b1;
    @(posedge clock);
    #1;
    stack_load = 1'b0;
    esp = 16'hFE80;
    chk(stack_pointer_reg, esp);
    t_branches();
    t_calls();
    t_operands();
    t_registers();
    report_and_stop();
  end
endmodule : boag_addr_gen_test
